/* File: crc56_step.sv */
// One-dword step of the 56-bit identification key CRC
`timescale 1ns/1ps
`include "lookup_map.svh"

module crc56_step (
  // Running remainder and next key dword
  input  wire logic [55:0] crc_in,
  input  wire logic [31:0] data,
  // Remainder after the dword
  output logic      [55:0] crc_out
);

  // Bit-serial division, most significant data bit first
  always_comb begin
    logic [55:0] c;
    c = crc_in;
    for (int i = 31; i >= 0; i--) begin
      if (c[55] ^ data[i]) begin
        c = {c[54:0], 1'b0} ^ `CRC_POLY;
      end else begin
        c = {c[54:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule : crc56_step

/* File: lookup_map.svh */
// Address map, codes and constants of the packet look-up key generator
`ifndef LOOKUP_MAP_SVH
`define LOOKUP_MAP_SVH

// ----------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------
`define PROF_BASE      12'h000
`define PROF_LAST      12'h3fc
`define NODE_BASE      12'h400
`define NODE_LAST      12'h43c
`define STATUS_ADDR    12'h500
`define CTRL_ADDR      12'h504
`define CTRL_RESET     1'h1

// ----------------------------------------------------------------------
// Profile memory entry layout (word index inside a 16-word entry)
// ----------------------------------------------------------------------
`define MASK_WORDS     4'ha
`define OPT_V4_WORD    4'ha
`define OPT_HOP_WORD   4'hb
`define OPT_DST_WORD   4'hc
`define TOS_V4_WORD    4'hd
`define TOS_V6_WORD    4'he

// ----------------------------------------------------------------------
// Key layouts and hashing
// ----------------------------------------------------------------------
`define KEY_LEN_SHORT  4'h4
`define KEY_LEN_LONG   4'ha
`define CRC_POLY       56'h00_0000_0000_0095
`define CRC_INIT       56'hff_ffff_ffff_ffff

// ----------------------------------------------------------------------
// Initial search structure addresses
// ----------------------------------------------------------------------
`define NODE_ADDR_BASE 16'h1000
`define NODE_ADDR_STEP 4'h7

// ----------------------------------------------------------------------
// Default node actions and treatment codes
// ----------------------------------------------------------------------
`define ACT_DISCARD    3'h0
`define ACT_CPU        3'h1
`define ACT_PORT_A     3'h2
`define ACT_PORT_B     3'h3
`define ACT_TREE       3'h4
`define OPT_SKIP       2'h1
`define OPT_CPU        2'h2
`define OPT_DELETE     2'h3
`define TOS_LOW        2'h2
`define TOS_HIGH       2'h3

`endif

/* File: lookup_pkg.sv */
// Types shared by the packet look-up key generator
package lookup_pkg;

  // Packet type as found by the parser
  typedef enum logic [3:0] {
    PT_NULL_RAW = 4'h1, PT_NON_IP = 4'h2, PT_V4_UDP = 4'h3, PT_V4_OTHER = 4'h4,
    PT_V6_UDP = 4'h5, PT_V6_OTHER = 4'h6, PT_IPVX = 4'h7, PT_ELAN = 4'h8,
    PT_MPOA = 4'h9, PT_MPLS = 4'ha
  } ptype_t;

  // Parsed header fields handed over by the parser
  typedef struct packed {
    ptype_t       ptype;
    logic [127:0] src_ip;
    logic [127:0] dst_ip;
    logic [15:0]  src_port;
    logic [15:0]  dst_port;
    logic [31:0]  ssrc;
    logic         rtp_present;
    logic [23:0]  flow_ptr;
    logic [31:0]  emulated_lan_tag;
    logic         opt_present;
    logic [1:0]   opt_kind;
    logic [7:0]   opt_value;
    logic         tos_present;
    logic [7:0]   tos_value;
  } pkt_t;

  // Classification result for the tree search
  typedef struct packed {
    logic [2:0]  action;
    logic [15:0] node_addr;
    logic [3:0]  profile;
    logic [59:0] key;
    logic [1:0]  opt_code;
    logic [1:0]  tos_code;
  } result_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_NODE = 3'b010, ST_HASH = 3'b100
  } state_t;

  // All flip-flop state of the top module except the profile and node tables
  typedef struct packed {
    state_t      st;
    pkt_t        pkt;
    result_t     res;
    logic        res_valid;
    logic        in_ready;
    logic [3:0]  idx;
    logic [3:0]  len;
    logic [55:0] crc;
    logic        enable;
    logic [15:0] count;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } top_state_t;

endpackage : lookup_pkg

/* File: packet_lookup_key_gen.sv */
// Packet look-up key generator: default node, key build, mask, CRC
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "lookup_map.svh"

module packet_lookup_key_gen (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  // Parsed packet from the parser
  input  wire logic                  in_valid,
  input  wire lookup_pkg::pkt_t      in_pkt,
  output logic                       in_ready,
  // Result to the tree search
  output logic                       res_valid,
  output lookup_pkg::result_t        res
);
  import lookup_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Profile memory: 16 entries of 16 words, word 15 unused
  logic [31:0] prof_mem [0:255];
  // Default node table: [2:0] action, [6:3] profile
  logic [6:0]  node_mem [0:15];

  top_state_t  s;
  top_state_t  next_s;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Two-bit code out of a 16-code word of an entry
  function automatic logic [1:0] pick_code(input logic [7:0] value,
                                           input logic [3:0] word);
    logic [31:0] w;
    w = prof_mem[{value[7:4], word}];
    return w[{value[3:0], 1'b0} +: 2];
  endfunction : pick_code

  // Profile memory word is mapped when it is not the spare word 15
  function automatic logic prof_hit(input logic [11:0] a);
    return (a <= `PROF_LAST) && (a[5:2] != 4'hf);
  endfunction : prof_hit

  // Key dword n of the layout selected by the packet type
  function automatic logic [31:0] key_word(input pkt_t p, input logic [3:0] n);
    logic [31:0] w;
    logic        v6;
    logic        udp;
    w   = 32'h0000_0000;
    v6  = (p.ptype == PT_V6_UDP) || (p.ptype == PT_V6_OTHER);
    udp = (p.ptype == PT_V4_UDP) || (p.ptype == PT_V6_UDP);
    if ((p.ptype == PT_V4_UDP) || (p.ptype == PT_V4_OTHER)) begin
      case (n)
        4'h0: w = p.src_ip[31:0];
        4'h1: w = p.dst_ip[31:0];
        4'h2: w = udp ? {p.src_port, p.dst_port} : 32'h0000_0000;
        4'h3: w = (udp && p.rtp_present) ? p.ssrc : 32'h0000_0000;
        default: w = 32'h0000_0000;
      endcase
    end else if (v6) begin
      case (n)
        4'h0: w = p.src_ip[127:96];
        4'h1: w = p.src_ip[95:64];
        4'h2: w = p.src_ip[63:32];
        4'h3: w = p.src_ip[31:0];
        4'h4: w = p.dst_ip[127:96];
        4'h5: w = p.dst_ip[95:64];
        4'h6: w = p.dst_ip[63:32];
        4'h7: w = p.dst_ip[31:0];
        4'h8: w = udp ? {p.src_port, p.dst_port} : 32'h0000_0000;
        4'h9: w = (udp && p.rtp_present) ? p.ssrc : 32'h0000_0000;
        default: w = 32'h0000_0000;
      endcase
    end else begin
      case (n)
        4'h0: w = {8'h00, p.flow_ptr};
        4'h1: begin
          if (p.ptype == PT_ELAN) begin
            w = p.emulated_lan_tag;
          end else if ((p.ptype != PT_NULL_RAW) || p.rtp_present) begin
            w = p.ssrc;
          end
        end
        default: w = 32'h0000_0000;
      endcase
    end
    return w;
  endfunction : key_word

  // ----------------------------------------------------------------------
  // Hash datapath
  // ----------------------------------------------------------------------
  logic [31:0] masked_word;
  logic [55:0] crc_next;

  // Mask word indexed by s.idx, which stays below the key length only in ST_HASH
  assign masked_word = key_word(s.pkt, s.idx)
                     & prof_mem[{s.res.profile, s.idx}];

  crc56_step u_crc (
    .crc_in  (s.crc),
    .data    (masked_word),
    .crc_out (crc_next)
  );

  // ----------------------------------------------------------------------
  // Memory writes from APB
  // ----------------------------------------------------------------------
  logic apb_wr;
  assign apb_wr = psel && penable && pwrite && !s.pready;

  // No reset on the tables; the block leaves reset enabled, so software loads them before sending packets
  always_ff @(posedge pclk) begin
    if (apb_wr && prof_hit(paddr)) begin
      prof_mem[paddr[9:2]] <= pwdata;
    end
    if (apb_wr && (paddr >= `NODE_BASE) && (paddr <= `NODE_LAST)) begin
      node_mem[paddr[5:2]] <= pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [6:0] node;
    logic [2:0] act;
    node   = node_mem[s.pkt.ptype];
    act    = node[2:0];
    next_s = s;
    next_s.res_valid = 1'b0;

    // APB: one wait state, answer registered in the second access cycle
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (prof_hit(paddr)) begin
        next_s.prdata = pwrite ? 32'h0000_0000 : prof_mem[paddr[9:2]];
      end else if ((paddr >= `NODE_BASE) && (paddr <= `NODE_LAST)) begin
        next_s.prdata = {25'h0000000, node_mem[paddr[5:2]]};
      end else if (paddr == `STATUS_ADDR) begin
        next_s.pslverr = pwrite;
        next_s.prdata  = {s.count, 13'h0000, s.st};
      end else if (paddr == `CTRL_ADDR) begin
        next_s.prdata = {31'h00000000, s.enable};
        if (pwrite) begin
          next_s.enable = pwdata[0];
        end
      end else begin
        next_s.pslverr = 1'b1;
      end
      if (pwrite) begin
        next_s.prdata = 32'h0000_0000;
      end
    end

    // Packet sequencer
    case (s.st)
      ST_IDLE: begin
        if (in_valid && s.in_ready) begin
          next_s.pkt      = in_pkt;
          next_s.in_ready = 1'b0;
          next_s.st       = ST_NODE;
          // Option and service codes live by value, not by profile
          next_s.res.opt_code = 2'h0;
          if (in_pkt.opt_present) begin
            case (in_pkt.opt_kind)
              2'h0:    next_s.res.opt_code = pick_code(in_pkt.opt_value, `OPT_V4_WORD);
              2'h1:    next_s.res.opt_code = pick_code(in_pkt.opt_value, `OPT_HOP_WORD);
              default: next_s.res.opt_code = pick_code(in_pkt.opt_value, `OPT_DST_WORD);
            endcase
          end
          next_s.res.tos_code = 2'h0;
          if (in_pkt.tos_present) begin
            if ((in_pkt.ptype == PT_V6_UDP) || (in_pkt.ptype == PT_V6_OTHER)) begin
              next_s.res.tos_code = pick_code(in_pkt.tos_value, `TOS_V6_WORD);
            end else begin
              next_s.res.tos_code = pick_code(in_pkt.tos_value, `TOS_V4_WORD);
            end
          end
        end else begin
          next_s.in_ready = s.enable;
        end
      end
      ST_NODE: begin
        // Default node of the packet type decides first
        next_s.res.node_addr = `NODE_ADDR_BASE
                             + {5'h00, s.pkt.ptype - 4'h1, 7'h00};
        next_s.res.profile   = node[6:3];
        next_s.res.key       = 60'h0;
        next_s.res.action    = act;
        if ((s.pkt.ptype == PT_NON_IP) || (s.pkt.ptype == PT_IPVX)) begin
          if (act == `ACT_TREE) begin
            next_s.res.action = `ACT_CPU;
          end
        end
        if (s.res.opt_code == `OPT_DELETE) begin
          next_s.res.action = `ACT_DISCARD;
        end else if (s.res.opt_code == `OPT_CPU) begin
          next_s.res.action = `ACT_CPU;
        end
        if (next_s.res.action == `ACT_TREE) begin
          next_s.st  = ST_HASH;
          next_s.idx = 4'h0;
          next_s.crc = `CRC_INIT;
          next_s.len = ((s.pkt.ptype == PT_V6_UDP) || (s.pkt.ptype == PT_V6_OTHER))
                     ? `KEY_LEN_LONG : `KEY_LEN_SHORT;
        end else begin
          next_s.st        = ST_IDLE;
          next_s.res_valid = 1'b1;
          next_s.in_ready  = s.enable;
          next_s.count     = s.count + 16'h0001;
        end
      end
      ST_HASH: begin
        // One masked key dword per clock
        next_s.crc = crc_next;
        next_s.idx = s.idx + 4'h1;
        if (s.idx == s.len - 4'h1) begin
          next_s.res.key   = {crc_next, s.res.profile};
          next_s.st        = ST_IDLE;
          next_s.res_valid = 1'b1;
          next_s.in_ready  = s.enable;
          next_s.count     = s.count + 16'h0001;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s        <= '0;
      s.st     <= ST_IDLE;
      s.enable <= `CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign pready    = s.pready;
  assign prdata    = s.prdata;
  assign pslverr   = s.pslverr;
  assign in_ready  = s.in_ready;
  assign res_valid = s.res_valid;
  // Priority code passed on; 01 is reserved and the search keeps priority
  assign res       = s.res;

endmodule : packet_lookup_key_gen

/* File: packet_lookup_key_gen_chk.sv */
// Port-level assertions for the packet look-up key generator
`timescale 1ns/1ps
`include "lookup_map.svh"

module packet_lookup_key_gen_chk (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  // Packet hand-off and result
  input wire logic                in_valid,
  input wire logic                in_ready,
  input wire logic                res_valid,
  input wire lookup_pkg::result_t res
);
  import lookup_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // APB answer and packet steps
  // ----------------------------------------------------------------
  sequence s_take; in_valid && in_ready; endsequence
  sequence s_done; res_valid && in_ready; endsequence

  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_NODE_FIRST: assert property (s_take |=> !in_ready ##[1:11] s_done)
    else $error("result out of time");
  AST_RES_PULSE: assert property (res_valid |=> !res_valid)
    else $error("res_valid too long");
  // Working fields share the result register, so only an idle block must hold it
  AST_RES_HELD: assert property (in_ready && !in_valid |=> $stable(res))
    else $error("result moved while idle");
  AST_NO_TREE_NON_IP: assert property (res_valid && res.action == `ACT_TREE
    |-> !(res.node_addr inside {16'h1080, 16'h1300})) else $error("non-IP in tree");
  AST_NODE_ADDR: assert property (res_valid |-> res.node_addr[6:0] == 7'h0
    && res.node_addr >= 16'h1000 && res.node_addr <= 16'h1480) else $error("bad node");
  AST_KEY_PROFILE: assert property (res_valid && res.action == `ACT_TREE
    |-> res.key[3:0] == res.profile) else $error("profile not in key");
  AST_KEY_CLEAR: assert property (res_valid && res.action != `ACT_TREE
    |-> res.key == 60'h0) else $error("key without tree");
  AST_OPT_DELETE: assert property (res_valid && res.opt_code == `OPT_DELETE
    |-> res.action == `ACT_DISCARD) else $error("deleted packet kept");
endmodule : packet_lookup_key_gen_chk

bind packet_lookup_key_gen packet_lookup_key_gen_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .in_valid, .in_ready, .res_valid, .res);

/* File: parser_model.sv */
// Behavioural packet parser feeding the key generator
`timescale 1ns/1ps

module parser_model (
  // Clock
  input  wire logic        pclk,
  // Hand-off to the key generator
  input  wire logic        in_ready,
  output logic             in_valid,
  output lookup_pkg::pkt_t in_pkt
);
  import lookup_pkg::*;

  // Idle outputs
  initial begin
    in_valid = 1'b0;
    in_pkt   = '0;
  end

  // Offer one packet, hold until taken or 50 edges pass; fields then show junk, not a stale copy
  task automatic send(input pkt_t p, output bit ok);
    ok = 1'b0;
    in_valid <= 1'b1;
    in_pkt   <= p;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge pclk);
      ok = in_ready;
    end
    in_valid <= 1'b0;
    in_pkt   <= ~p;
  endtask : send
endmodule : parser_model

/* File: test_packet_lookup_key_gen.sv */
// Self-checking bench for the packet look-up key generator
`timescale 1ns/1ps
`include "lookup_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: got %h expected %h", $time, (a), (b)); end end

module test_packet_lookup_key_gen;
  import lookup_pkg::*;

  // Table row: node setting and expected action
  typedef struct packed {
    ptype_t     t;
    logic [2:0] act;
    logic [3:0] prof;
    logic [2:0] exp_act;
    logic       rtp;
  } row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        in_valid;
  pkt_t        in_pkt;
  logic        in_ready;
  logic        res_valid;
  result_t     res;
  int          err_count = 0;
  int          n_checks = 0;
  int          lat;
  logic [31:0] rd;
  logic        er;
  logic [59:0] ek;
  bit          ok;
  pkt_t        p;
  row_t        rows [12] = '{
    '{PT_V4_UDP,   `ACT_TREE,    4'h1, `ACT_TREE,    1'b1},
    '{PT_V4_UDP,   `ACT_TREE,    4'h2, `ACT_TREE,    1'b0},
    '{PT_V4_OTHER, `ACT_TREE,    4'h1, `ACT_TREE,    1'b1},
    '{PT_V6_UDP,   `ACT_TREE,    4'h2, `ACT_TREE,    1'b1},
    '{PT_V6_OTHER, `ACT_PORT_B,  4'h2, `ACT_PORT_B,  1'b1},
    '{PT_NULL_RAW, `ACT_TREE,    4'h3, `ACT_TREE,    1'b0},
    '{PT_NULL_RAW, `ACT_TREE,    4'h3, `ACT_TREE,    1'b1},
    '{PT_ELAN,     `ACT_TREE,    4'h3, `ACT_TREE,    1'b1},
    '{PT_MPOA,     `ACT_TREE,    4'h0, `ACT_TREE,    1'b1},
    '{PT_MPLS,     `ACT_DISCARD, 4'h0, `ACT_DISCARD, 1'b1},
    '{PT_IPVX,     `ACT_TREE,    4'h0, `ACT_CPU,     1'b1},
    '{PT_NON_IP,   `ACT_PORT_A,  4'h0, `ACT_PORT_A,  1'b1}
  };

  always #4 pclk = ~pclk;

  packet_lookup_key_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .in_valid(in_valid), .in_pkt(in_pkt), .in_ready(in_ready),
    .res_valid(res_valid), .res(res));
  parser_model pm (.pclk(pclk), .in_ready(in_ready), .in_valid(in_valid), .in_pkt(in_pkt));

  // Mask with one cleared bit per dword; profile 1 drops the SSRC dword
  function automatic logic [31:0] mk(input int pr, input int w);
    return (pr == 1 && w == 3) ? 32'h0 : ~(32'h1 << (pr * 4 + w));
  endfunction : mk

  // Expected key: layout, mask, MSB-first CRC, then profile
  function automatic logic [59:0] exp_key(input pkt_t q, input int pr);
    logic [31:0] d [10];
    logic [31:0] m;
    logic [55:0] c;
    int          n;
    d = '{default: 32'h0};
    n = 4;
    if (q.ptype inside {PT_V4_UDP, PT_V4_OTHER}) begin
      d[0] = q.src_ip[31:0];
      d[1] = q.dst_ip[31:0];
    end else if (q.ptype inside {PT_V6_UDP, PT_V6_OTHER}) begin
      n = 10;
      for (int k = 0; k < 4; k++) begin
        d[k] = q.src_ip[127 - 32 * k -: 32];
        d[k + 4] = q.dst_ip[127 - 32 * k -: 32];
      end
    end else begin
      d[0] = {8'h00, q.flow_ptr};
      d[1] = (q.ptype == PT_ELAN) ? q.emulated_lan_tag
           : (q.rtp_present || q.ptype != PT_NULL_RAW) ? q.ssrc : 32'h0;
    end
    if (q.ptype inside {PT_V4_UDP, PT_V6_UDP}) begin
      d[n - 2] = {q.src_port, q.dst_port};
      d[n - 1] = q.rtp_present ? q.ssrc : 32'h0;
    end
    c = `CRC_INIT;
    for (int w = 0; w < n; w++) begin
      m = mk(pr, w) & d[w];
      for (int b = 31; b >= 0; b--) begin
        c = {c[54:0], 1'b0} ^ ((c[55] ^ m[b]) ? `CRC_POLY : 56'h0);
      end
    end
    return {c, 4'(pr)};
  endfunction : exp_key

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic fail_wait;
    err_count++;
    $display("Error %0t: wait ran out", $time);
    complete_run();
  endtask : fail_wait

  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) fail_wait();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Send one packet and count edges to its result
  task automatic run_pkt(input pkt_t q);
    pm.send(q, ok);
    if (!ok) fail_wait();
    for (lat = 1; lat < 40; lat++) begin
      @(posedge pclk);
      if (res_valid === 1'b1) break;
    end
    if (lat == 40) fail_wait();
  endtask : run_pkt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    p = '0;
    p.src_ip = 128'h0102_0304_0506_0708_090a_0b0c_c0a8_0001;
    p.dst_ip = 128'h1020_3040_5060_7080_90a0_b0c0_0a00_0002;
    p.src_port = 16'h1f40;
    p.dst_port = 16'h2710;
    p.ssrc = 32'h5a5a_3c3c;
    p.flow_ptr = 24'h12_3456;
    p.emulated_lan_tag = 32'h0000_0abc;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({pready, pslverr, res_valid, in_ready, res}, '0)
    repeat (2) @(posedge pclk);
    `CHK(in_ready, 1'b1)
    $display("reset test done");
    apb(1'b0, `CTRL_ADDR, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b0, `STATUS_ADDR, 32'h0);
    `CHK(rd, 32'h1)
    foreach (rows[i]) begin
      apb(1'b1, 12'h03c + 12'(i) * 12'h040, 32'h0);
      `CHK(er, 1'b1)
    end
    // Entry 0/1 words carry option and service codes: value v maps to code v
    for (int pr = 0; pr < 4; pr++) begin
      for (int w = 0; w < 10; w++) apb(1'b1, 12'(pr * 64 + w * 4), mk(pr, w));
    end
    for (int w = 10; w < 14; w++) apb(1'b1, 12'(w * 4), 32'h0000_00e4);
    apb(1'b1, 12'h078, 32'h0000_00e4);
    apb(1'b0, 12'h04c, 32'h0);
    `CHK({er, rd}, {1'b0, mk(1, 3)})
    $display("register test done");
    foreach (rows[i]) begin
      apb(1'b1, `NODE_BASE + 12'(rows[i].t) * 12'h4,
          {25'h0, rows[i].prof, rows[i].act});
      p.ptype = rows[i].t;
      p.rtp_present = rows[i].rtp;
      run_pkt(p);
      `CHK(res.action, rows[i].exp_act)
      `CHK(res.node_addr, 16'h1000 + 16'(rows[i].t - 1) * 16'h80)
      if (rows[i].exp_act == `ACT_TREE) begin
        `CHK(res.profile, rows[i].prof)
        ek = exp_key(p, rows[i].prof);
        `CHK(res.key[59:4], ek[59:4])
        `CHK(res.key, ek)
      end
      `CHK(lat, rows[i].exp_act != `ACT_TREE ? 2 : (rows[i].t == PT_V6_UDP ? 12 : 6))
    end
    $display("table test done");
    for (int v = 0; v < 4; v++) begin
      p.ptype = PT_V4_UDP;
      p.opt_present = 1'b1;
      p.opt_kind = 2'h0;
      p.opt_value = 8'(v);
      p.tos_present = 1'b1;
      p.tos_value = 8'(v);
      for (int k = 0; k < 2; k++) begin
        run_pkt(p);
        `CHK(res.opt_code, 2'(v))
        `CHK(res.tos_code, 2'(v))
        `CHK(res.action, v == 3 ? `ACT_DISCARD : v == 2 ? `ACT_CPU : `ACT_TREE)
        p.ptype = PT_V6_UDP;
        p.opt_kind = 2'(1 + v % 2);
        p.tos_value = 8'(16 + v);
      end
    end
    $display("code test done");
    // Disabled block must refuse packets; STATUS refuses writes
    apb(1'b1, `CTRL_ADDR, 32'h0);
    apb(1'b1, `STATUS_ADDR, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b0, `STATUS_ADDR, 32'h0);
    `CHK(rd, {16'($size(rows) + 8), 16'h0001})
    `CHK(in_ready, 1'b0)
    pm.send(p, ok);
    `CHK(ok, 1'b0)
    $display("enable test done");
    // Reset in mid-run clears the result and the count, and re-enables
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK({pready, pslverr, res_valid, in_ready, res}, '0)
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(in_ready, 1'b1)
    apb(1'b0, `STATUS_ADDR, 32'h0);
    `CHK(rd, 32'h1)
    $display("second reset test done");
    complete_run();
  end
endmodule : test_packet_lookup_key_gen
